// ---- design/pwm_modes_ir_fifo.sv ----
// six pwm channel engines, channel 0 modes, element queue control and register slave
`timescale 1ns/1ns
`default_nettype none
module pwm_modes_ir_fifo import pwm_pkg::*; (
	// clock, reset, clock enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// avalon-mm slave
	input wire bus_req_type avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// dma channel feeding the queue
	input wire dma_word_type dma_word,
	input wire logic dma_start,
	output logic dma_ready,
	// pins and interrupt
	output logic [NCH-1:0] pwm_out,
	output logic irq
);
	typedef struct packed {
		logic [NCH-1:0] en;
		logic [7:0] div;
		logic [7:0] mode;
		logic [NCH-1:0][15:0] cmp;
		logic [NCH-1:0][15:0] per;
		logic [15:0] alt_cmp;
		logic [15:0] alt_per;
		logic [PNW-1:0] pnum;
		logic [7:0] fmask;
		logic [7:0] fflag;
		logic [7:0] qmask;
		logic [7:0] qflag;
		logic [QCW-1:0] thresh;
		logic [7:0] dcnt;
		logic [NCH-1:0] run;
		logic [NCH-1:0][15:0] cnt;
		logic [NCH-1:0][15:0] cmp_a;
		logic [NCH-1:0][15:0] per_a;
		logic [PNW-1:0] pcnt;
		logic [PNW-1:0] pnum_a;
		logic carrier;
		logic [QPW-1:0] wp;
		logic [QPW-1:0] rp;
		logic [QCW-1:0] qcnt;
		logic [QCW-1:0] qcnt_d;
		logic pop_d;
		logic [31:0] pbuf;
		logic [3:0] pmask;
		logic pcpu;
		logic dma_rdy;
		logic waitreq;
		logic [31:0] rdata;
		logic [NCH-1:0] out;
		logic irq;
	} state_type;

	state_type st_reg, st_next;
	logic [15:0] elem;
	logic push;
	logic [10:0] idx;
	logic [3:0] be;
	logic [31:0] wd;
	logic [31:0] rv;
	logic tick;
	logic idle;
	logic win;
	logic room;
	logic [4:0] nb;
	logic [NCH-1:0] fend;
	logic [NCH-1:0] strt;
	logic [7:0] fset;
	logic [7:0] fclr;
	logic [7:0] qset;
	logic [7:0] qclr;
	logic grp_end;
	logic qmode;
	logic cntmode;
	logic irmode;
	logic q_ok;
	logic pop;
	logic flush;
	logic need;

	assign push = st_reg.pmask[0];

	queue_mem u_mem (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.wr_en(push),
		.wr_addr(st_reg.wp),
		.wr_data(st_reg.pbuf[7:0]),
		.rd_addr(st_reg.rp),
		.rd_data(elem)
	);

	always_comb begin
		st_next = st_reg;
		idx = avs_req.address[12:2];
		be = avs_req.byteenable;
		wd = avs_req.writedata;
		fset = '0;
		fclr = '0;
		qset = '0;
		qclr = '0;
		flush = 1'b0;
		pop = 1'b0;
		rv = '0;
		fend = '0;
		strt = '0;

		// divided counter clock; >= so a divider lowered mid-count never wraps the count
		tick = (st_reg.dcnt >= st_reg.div); // R23
		st_next.dcnt = tick ? 8'h00 : st_reg.dcnt + 8'h01; // R23

		// channel 0 mode decode, anything else is free-running
		cntmode = (st_reg.mode[3:0] == MODE_COUNT); // R1
		irmode = (st_reg.mode[3:0] == MODE_IR); // R1
		qmode = (st_reg.mode[3:0] == MODE_QCPU) || (st_reg.mode[3:0] == MODE_QDMA); // R1

		// frame engines shared by every channel
		for (int c = 0; c < NCH; c++) begin
			fend[c] = st_reg.run[c] && tick && (st_reg.cnt[c] + 16'h0001 >= st_reg.per_a[c]); // R22
			strt[c] = st_reg.en[c] && tick && (!st_reg.run[c] || fend[c]); // R3
			if (tick && st_reg.run[c]) begin
				st_next.cnt[c] = st_reg.cnt[c] + 16'h0001; // R22
			end
			if (fend[c]) begin
				fset[FLAG_FRAME0 + c] = 1'b1; // R5
			end
			if (strt[c]) begin
				st_next.run[c] = 1'b1; // R3
				st_next.cnt[c] = '0;
				st_next.cmp_a[c] = st_reg.cmp[c]; // R4
				st_next.per_a[c] = st_reg.per[c]; // R4
			end else if (fend[c]) begin
				st_next.run[c] = 1'b0;
			end
			if (!st_reg.en[c]) begin
				st_next.run[c] = 1'b0; // R3
			end
		end

		// channel 0 alone carries the group and queue modes
		grp_end = fend[0] && (st_reg.pcnt + 14'h0001 >= st_reg.pnum_a); // R6
		q_ok = (st_reg.qcnt_d >= ELEM_BYTES) && !st_reg.pop_d;
		need = st_reg.en[0] && tick && (!st_reg.run[0] || grp_end);
		if (fend[0]) begin
			st_next.pcnt = st_reg.pcnt + 14'h0001;
		end
		if (cntmode || irmode) begin // R2
			if (fend[0] && !grp_end) begin
				st_next.cmp_a[0] = st_reg.cmp_a[0]; // R9
				st_next.per_a[0] = st_reg.per_a[0]; // R9
			end
			if (strt[0] && (!st_reg.run[0] || grp_end)) begin // R8
				st_next.pcnt = '0;
				st_next.pnum_a = st_reg.pnum; // R9
				st_next.carrier = 1'b1;
			end
			if (grp_end) begin
				fset[FLAG_GROUP] = 1'b1; // R7 R11
				if (cntmode) begin
					st_next.en[0] = 1'b0; // R7 R10
					st_next.run[0] = 1'b0; // R10
				end
			end
		end else if (qmode) begin
			if (fend[0] && !grp_end) begin
				st_next.cmp_a[0] = st_reg.cmp_a[0];
				st_next.per_a[0] = st_reg.per_a[0];
			end
			if (need) begin
				if (q_ok) begin
					pop = 1'b1; // R16
					st_next.run[0] = 1'b1;
					st_next.cnt[0] = '0;
					st_next.pcnt = '0;
					st_next.pnum_a = elem[PNW-1:0]; // R12
					st_next.carrier = elem[ELEM_CARRIER]; // R12 R25
					st_next.cmp_a[0] = elem[ELEM_ALT] ? st_reg.alt_cmp : st_reg.cmp[0]; // R13
					st_next.per_a[0] = elem[ELEM_ALT] ? st_reg.alt_per : st_reg.per[0]; // R13 R25
				end else begin
					st_next.run[0] = 1'b0;
					if (st_reg.run[0]) begin
						st_next.en[0] = 1'b0; // R17
						qset[QFLAG_STOP] = 1'b1; // R20
						if (st_reg.mode[3:0] == MODE_QDMA) begin
							fset[FLAG_DMA_END] = 1'b1;
						end
					end
				end
			end
		end else if (strt[0]) begin
			st_next.carrier = 1'b1;
		end
		if ((st_reg.mode[3:0] == MODE_QCPU) && (st_reg.qcnt < st_reg.thresh)) begin
			qset[QFLAG_LEVEL] = 1'b1; // R24
		end

		// byte pusher, one byte a clock, lanes low first
		if (st_reg.pmask != 4'h0) begin
			st_next.pbuf = st_reg.pbuf >> 8;
			st_next.pmask = st_reg.pmask >> 1;
		end
		idle = (st_reg.pmask == 4'h0) && !st_reg.dma_rdy;
		win = (idx >= IDX_WIN_FIRST) && (idx <= IDX_WIN_LAST);
		nb = 5'(be[0]) + 5'(be[1]) + 5'(be[2]) + 5'(be[3]);
		room = (5'(st_reg.qcnt) + nb) <= QDEPTH_W;
		if (st_reg.dma_rdy) begin
			st_next.pbuf = dma_word.data; // R21
			st_next.pmask = 4'hF;
		end
		st_next.dma_rdy = (st_reg.mode[3:0] == MODE_QDMA) && dma_word.valid && idle && !st_reg.pcpu
			&& !(st_reg.waitreq && avs_req.write && win)
			&& ((5'(st_reg.qcnt) + 5'h04) <= QDEPTH_W); // R19

		// register read view
		case (idx)
			IDX_EN_HI: rv[NCH-1:1] = st_reg.en[NCH-1:1];
			IDX_EN0: rv[0] = st_reg.en[0];
			IDX_DIV: rv[7:0] = st_reg.div;
			IDX_MODE: rv[7:0] = st_reg.mode;
			IDX_PNUM: rv[PNW-1:0] = st_reg.pnum;
			IDX_FMASK: rv[7:0] = st_reg.fmask;
			IDX_FFLAG: rv[7:0] = st_reg.fflag;
			IDX_QMASK: rv[7:0] = st_reg.qmask;
			IDX_QFLAG: rv[7:0] = st_reg.qflag;
			IDX_PCNT: rv[PNW-1:0] = st_reg.pcnt;
			IDX_ALT_CMP: rv[15:0] = st_reg.alt_cmp;
			IDX_ALT_PER: rv[15:0] = st_reg.alt_per;
			IDX_THRESH: rv[QCW-1:0] = st_reg.thresh;
			IDX_QSTAT: begin
				rv[QCW-1:0] = st_reg.qcnt; // R15
				rv[QSTAT_EMPTY] = (st_reg.qcnt == 4'h0); // R15
				rv[QSTAT_FULL] = (st_reg.qcnt == QDEPTH_C); // R15
			end
			default: begin
				for (int c = 0; c < NCH; c++) begin
					if (idx == IDX_TIME_BASE + 11'(c * TIME_STRIDE)) begin
						rv[15:0] = st_reg.cmp[c];
					end
					if (idx == IDX_TIME_BASE + 11'(c * TIME_STRIDE + PER_OFS)) begin
						rv[15:0] = st_reg.per[c];
					end
					if (idx == IDX_CNT_BASE + 11'(c * CNT_STRIDE)) begin
						rv[15:0] = st_reg.cnt[c];
					end
				end
			end
		endcase

		// bus handshake: answer one clock after the request is seen with the byte pusher idle; window writes once their bytes are pushed
		st_next.waitreq = 1'b1;
		if (st_reg.waitreq && (avs_req.read || avs_req.write) && idle) begin
			if (st_reg.pcpu) begin
				st_next.pcpu = 1'b0;
				st_next.waitreq = 1'b0;
			end else if (avs_req.write && win) begin
				st_next.pcpu = 1'b1;
				st_next.pbuf = wd; // R14
				st_next.pmask = room ? be : 4'h0; // R26
			end else begin
				st_next.waitreq = 1'b0;
				st_next.rdata = rv;
			end
		end

		// writes take effect at the edge that ends the request
		if (!st_reg.waitreq && avs_req.write) begin
			case (idx)
				IDX_EN_HI: if (be[0]) st_next.en[NCH-1:1] = wd[NCH-1:1];
				IDX_EN0: if (be[0]) st_next.en[0] = wd[0];
				IDX_DIV: if (be[0]) st_next.div = wd[7:0];
				IDX_MODE: if (be[0]) st_next.mode = wd[7:0];
				IDX_FMASK: if (be[0]) st_next.fmask = wd[7:0];
				IDX_QMASK: if (be[0]) st_next.qmask = wd[7:0];
				IDX_FFLAG: if (be[0]) fclr = wd[7:0]; // R5
				IDX_QFLAG: if (be[0]) qclr = wd[7:0]; // R20
				IDX_THRESH: if (be[0]) st_next.thresh = wd[QCW-1:0];
				IDX_FLUSH: flush = be[0] && wd[0]; // R18
				IDX_PNUM: begin
					if (be[0]) st_next.pnum[7:0] = wd[7:0];
					if (be[1]) st_next.pnum[PNW-1:8] = wd[PNW-1:8];
				end
				IDX_ALT_CMP: begin
					if (be[0]) st_next.alt_cmp[7:0] = wd[7:0];
					if (be[1]) st_next.alt_cmp[15:8] = wd[15:8];
				end
				IDX_ALT_PER: begin
					if (be[0]) st_next.alt_per[7:0] = wd[7:0];
					if (be[1]) st_next.alt_per[15:8] = wd[15:8];
				end
				default: begin
					for (int c = 0; c < NCH; c++) begin
						if (idx == IDX_TIME_BASE + 11'(c * TIME_STRIDE)) begin
							if (be[0]) st_next.cmp[c][7:0] = wd[7:0];
							if (be[1]) st_next.cmp[c][15:8] = wd[15:8];
						end
						if (idx == IDX_TIME_BASE + 11'(c * TIME_STRIDE + PER_OFS)) begin
							if (be[0]) st_next.per[c][7:0] = wd[7:0];
							if (be[1]) st_next.per[c][15:8] = wd[15:8];
						end
					end
				end
			endcase
		end
		if (dma_start && (st_reg.mode[3:0] == MODE_QDMA)) begin
			st_next.en[0] = 1'b1; // R19
		end

		// queue bookkeeping
		st_next.wp = st_reg.wp + QPW'(push);
		st_next.rp = pop ? st_reg.rp + ELEM_STEP : st_reg.rp;
		st_next.qcnt = st_reg.qcnt + QCW'(push) - (pop ? ELEM_BYTES : 4'h0); // R15
		st_next.qcnt_d = st_reg.qcnt;
		st_next.pop_d = pop;
		if (flush) begin
			st_next.wp = '0; // R18
			st_next.rp = '0;
			st_next.qcnt = '0;
			st_next.pop_d = 1'b1;
		end

		// sticky flags: a set in the clearing cycle wins
		st_next.fflag = (st_reg.fflag & ~fclr) | fset; // R5 R7 R11
		st_next.qflag = (st_reg.qflag & ~qclr) | qset; // R20 R24

		// pins follow the new state, so a disable drops them at once
		for (int c = 0; c < NCH; c++) begin
			st_next.out[c] = st_next.en[c] && st_next.run[c] && (st_next.cnt[c] < st_next.cmp_a[c]); // R22 R3
		end
		st_next.out[0] = st_next.out[0] && st_next.carrier; // R25
		st_next.irq = |(st_next.fflag & st_next.fmask) || |(st_next.qflag & st_next.qmask); // R5 R20
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.waitreq <= 1'b1;
			st_reg.alt_cmp <= ALT_CMP_RST;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitreq;
	assign dma_ready = st_reg.dma_rdy;
	assign pwm_out = st_reg.out;
	assign irq = st_reg.irq;
endmodule : pwm_modes_ir_fifo
`default_nettype wire

// ---- design/pwm_pkg.sv ----
// shared constants and types of the pwm mode and ir queue block
// What this block does
// R1: mode nibble picks channel 0 operating mode
// R2: channels 1 to 5 free-running only
// R3: frames repeat until disabled; then low at once
// R4: new compare and period at next frame
// R5: frame end sets w1c cycle-done flag, masked
// R6: counted mode plays group count frames
// R7: group end clears enable, sets group flag
// R8: infrared mode repeats groups without stopping
// R9: infrared updates apply at next group start
// R10: counted mode finishes group; disable stops now
// R11: infrared sets frame and group flags
// R12: element: count 13:0, set 14, carrier 15
// R13: bit 14 picks primary or alternate timing
// R14: software writes element bytes through window
// R15: eight byte queue with count, empty, full
// R16: queued elements play in order while enabled
// R17: empty after last element clears enable
// R18: flush discards queue; also during playback
// R19: dma feeds queue; dma start sets enable
// R20: playback end sets queue-stop flag, masked
// R21: dma words carry two elements, low first
// R22: count level to compare, rest to period
// R23: counters tick every divider plus one clocks
// R24: cpu queue below threshold flags interrupt
// R25: low element holds output low per period
// R26: window write into full queue discarded
package pwm_pkg;
	localparam int NCH = 6;
	localparam int PNW = 14;
	localparam int QPW = 3;
	localparam int QCW = 4;
	localparam int TIME_STRIDE = 4;
	localparam int PER_OFS = 2;
	localparam int CNT_STRIDE = 2;
	// register indexes; byte address is four times the index
	localparam logic [10:0] IDX_EN_HI = 11'h780;
	localparam logic [10:0] IDX_EN0 = 11'h781;
	localparam logic [10:0] IDX_DIV = 11'h782;
	localparam logic [10:0] IDX_MODE = 11'h783;
	localparam logic [10:0] IDX_TIME_BASE = 11'h794;
	localparam logic [10:0] IDX_PNUM = 11'h7AC;
	localparam logic [10:0] IDX_FMASK = 11'h7B0;
	localparam logic [10:0] IDX_FFLAG = 11'h7B1;
	localparam logic [10:0] IDX_QMASK = 11'h7B2;
	localparam logic [10:0] IDX_QFLAG = 11'h7B3;
	localparam logic [10:0] IDX_CNT_BASE = 11'h7B4;
	localparam logic [10:0] IDX_PCNT = 11'h7C0;
	localparam logic [10:0] IDX_ALT_CMP = 11'h7C4;
	localparam logic [10:0] IDX_ALT_PER = 11'h7C6;
	localparam logic [10:0] IDX_WIN_FIRST = 11'h7C8;
	localparam logic [10:0] IDX_WIN_LAST = 11'h7CB;
	localparam logic [10:0] IDX_THRESH = 11'h7CC;
	localparam logic [10:0] IDX_QSTAT = 11'h7CD;
	localparam logic [10:0] IDX_FLUSH = 11'h7CE;
	// channel 0 mode codes
	localparam logic [3:0] MODE_COUNT = 4'h1;
	localparam logic [3:0] MODE_IR = 4'h3;
	localparam logic [3:0] MODE_QCPU = 4'h7;
	localparam logic [3:0] MODE_QDMA = 4'hF;
	// flag and field positions
	localparam int FLAG_GROUP = 0;
	localparam int FLAG_DMA_END = 1;
	localparam int FLAG_FRAME0 = 2;
	localparam int QFLAG_STOP = 0;
	localparam int QFLAG_LEVEL = 1;
	localparam int QSTAT_EMPTY = 4;
	localparam int QSTAT_FULL = 5;
	localparam int ELEM_ALT = 14;
	localparam int ELEM_CARRIER = 15;
	// queue sizes and reset values
	localparam logic [QCW-1:0] QDEPTH_C = 4'h8;
	localparam logic [4:0] QDEPTH_W = 5'h08;
	localparam logic [QCW-1:0] ELEM_BYTES = 4'h2;
	localparam logic [QPW-1:0] ELEM_STEP = 3'h2;
	localparam logic [15:0] ALT_CMP_RST = 16'h5555;
	typedef struct packed {
		logic read;
		logic write;
		logic [12:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} bus_req_type;
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} dma_word_type;
endpackage : pwm_pkg

// ---- design/queue_mem.sv ----
// byte-wide element queue storage with registered element read
`timescale 1ns/1ns
`default_nettype none
module queue_mem import pwm_pkg::*; (
	// clock, reset, clock enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// byte write
	input wire logic wr_en,
	input wire logic [QPW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// element read, two bytes low first
	input wire logic [QPW-1:0] rd_addr,
	output logic [15:0] rd_data
);
	typedef struct packed {
		logic [7:0][7:0] mem;
		logic [15:0] rd;
	} mem_state_type;
	mem_state_type st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		if (wr_en) begin
			st_next.mem[wr_addr] = wr_data;
		end
		st_next.rd = {st_reg.mem[QPW'(rd_addr + 1'b1)], st_reg.mem[rd_addr]};
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end
	assign rd_data = st_reg.rd;
endmodule : queue_mem
`default_nettype wire

// ---- dv/ir_load_model.sv ----
// load on the pwm pins: counts pulses and high cycles
`timescale 1ns/1ns
`default_nettype none
module ir_load_model import pwm_pkg::*; (
	// clock and counter clear
	input wire logic clk_sys,
	input wire logic clr,
	// pins
	input wire logic [NCH-1:0] pwm_out,
	// measurements
	output logic [15:0] rise0,
	output logic [15:0] rise1,
	output logic [15:0] high0
);
	logic [NCH-1:0] last;
	always_ff @(posedge clk_sys) begin
		last <= pwm_out;
		if (clr) begin
			rise0 <= 16'h0;
			rise1 <= 16'h0;
			high0 <= 16'h0;
		end else begin
			rise0 <= rise0 + 16'(pwm_out[0] & ~last[0]);
			rise1 <= rise1 + 16'(pwm_out[1] & ~last[1]);
			high0 <= high0 + 16'(pwm_out[0]);
		end
	end
endmodule : ir_load_model
`default_nettype wire

// ---- dv/pwm_modes_ir_fifo_sva.sv ----
// port assertions and covers for the pwm mode and queue block
`timescale 1ns/1ns
`default_nettype none
module pwm_modes_ir_fifo_sva import pwm_pkg::*; (
	// clock, reset, clock enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// bus
	input wire bus_req_type avs_req,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// dma
	input wire dma_word_type dma_word,
	input wire logic dma_start,
	input wire logic dma_ready,
	// pins and interrupt
	input wire logic [NCH-1:0] pwm_out,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn || !ce);
	a_wait_single_low: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_answer_has_req: assert property (!avs_waitrequest |-> $past(avs_req.read || avs_req.write))
		else $error("answer without a request");
	a_answer_bounded: assert property ((avs_req.read || avs_req.write) && avs_waitrequest |-> ##[0:12] !avs_waitrequest)
		else $error("bus request not answered in time");
	a_answer_not_same: assert property ($rose(avs_req.read || avs_req.write) |-> avs_waitrequest)
		else $error("answer in the cycle the request appeared");
	a_dma_pulse_gap: assert property (dma_ready |=> !dma_ready [*4])
		else $error("dma ready not a spaced single pulse");
	a_dma_after_valid: assert property (dma_ready |-> $past(dma_word.valid))
		else $error("dma ready without an offered word");
	a_quiet_at_release: assert property ($rose(rstn) |-> pwm_out == '0 && !irq && !dma_ready && avs_waitrequest)
		else $error("outputs not idle after reset");
	a_readdata_hold: assert property (avs_waitrequest && $past(rstn) |-> $stable(avs_readdata))
		else $error("read data changed outside an answer");
	c_window_write: cover property (avs_req.write && avs_req.address[12:2] == IDX_WIN_FIRST && !avs_waitrequest);
	c_dma_taken: cover property (dma_start ##[1:20] dma_ready);
	c_irq_rise: cover property ($rose(irq));
	c_pin0_fall: cover property ($fell(pwm_out[0]));
endmodule : pwm_modes_ir_fifo_sva
bind pwm_modes_ir_fifo pwm_modes_ir_fifo_sva u_sva (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .avs_req(avs_req),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_word(dma_word), .dma_start(dma_start),
	.dma_ready(dma_ready), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

// ---- dv/tb_pwm_modes_ir_fifo.sv ----
// testbench of the pwm mode and queue block
`timescale 1ns/1ns
`default_nettype none
module tb_pwm_modes_ir_fifo import pwm_pkg::*;;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic dma_start = 1'b0;
	logic clr = 1'b1;
	bus_req_type avs_req = '0;
	dma_word_type dma_word = '0;
	logic [31:0] avs_readdata;
	logic [31:0] rd;
	logic avs_waitrequest;
	logic dma_ready;
	logic irq;
	logic [NCH-1:0] pwm_out;
	logic [15:0] rise0;
	logic [15:0] rise1;
	logic [15:0] high0;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	integer seed = 62768;
	always #10 clk_sys = ~clk_sys;
	pwm_modes_ir_fifo u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .avs_req(avs_req), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .dma_word(dma_word), .dma_start(dma_start), .dma_ready(dma_ready),
		.pwm_out(pwm_out), .irq(irq));
	ir_load_model u_load (.clk_sys(clk_sys), .clr(clr), .pwm_out(pwm_out), .rise0(rise0), .rise1(rise1),
		.high0(high0));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic is_wr, input logic [10:0] idx, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_req <= '{read: !is_wr, write: is_wr, address: {idx, 2'b00}, writedata: d, byteenable: be};
		// waits as long as the answer takes; only the cycle ceiling ends a hang
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [10:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d, 4'hF);
	endtask : wr
	task automatic rdr(input logic [10:0] idx);
		bus(1'b0, idx, 32'h0, 4'hF);
	endtask : rdr
	task automatic wait_off();
		int n;
		n = 0;
		do begin
			rdr(IDX_EN0);
			n++;
		end while (rd[0] !== 1'b0 && n < 300);
	endtask : wait_off
	task automatic pulse_clr();
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
	endtask : pulse_clr
	function automatic logic [15:0] rnd(input int m);
		return 16'(1 + ($unsigned($random(seed)) % m));
	endfunction : rnd
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		logic [15:0] c;
		logic [15:0] k;
		logic [15:0] n0;
		logic [15:0] n2;
		logic [15:0] ac;
		int i;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		clr <= 1'b0;
		rdr(IDX_QSTAT);
		chk(rd, 32'h10);
		rdr(IDX_ALT_CMP);
		chk(rd, 32'h5555);
		rdr(11'h788);
		chk(rd, 32'h0);
		k = rnd(255);
		wr(IDX_MODE, 32'(k));
		rdr(IDX_MODE);
		chk(rd, 32'(k[7:0]));
		$display("test registers done");
		// channel 1 free running, frame flag and interrupt
		c = rnd(3);
		wr(11'h798, 32'(c));
		wr(11'h79A, 32'(c + 16'h2));
		wr(IDX_FMASK, 32'h08);
		pulse_clr();
		wr(IDX_EN_HI, 32'h02);
		repeat (20 * (c + 2)) @(posedge clk_sys);
		chk(32'(rise1 >= 16'h000F), 32'h1);
		chk(32'(rise0), 32'h0);
		chk(32'(irq), 32'h1);
		rdr(IDX_FFLAG);
		chk(32'(rd[3]), 32'h1);
		wr(IDX_EN_HI, 32'h0);
		@(negedge clk_sys);
		chk(32'(pwm_out[1]), 32'h0);
		wr(IDX_FFLAG, 32'hFF);
		rdr(IDX_FFLAG);
		chk(rd, 32'h0);
		chk(32'(irq), 32'h0);
		wr(IDX_FMASK, 32'h0);
		$display("test free running done");
		// counted group with divider
		c = rnd(3);
		k = rnd(8) + 16'h1;
		wr(IDX_DIV, 32'h1);
		wr(IDX_TIME_BASE, 32'(c));
		wr(11'h796, 32'(c + 16'h2));
		wr(IDX_PNUM, 32'(k));
		wr(IDX_MODE, 32'(MODE_COUNT));
		pulse_clr();
		wr(IDX_EN0, 32'h1);
		wait_off();
		chk(rd, 32'h0);
		chk(32'(rise0), 32'(k));
		chk(32'(high0), 32'(k * c * 16'h2));
		rdr(IDX_FFLAG);
		chk(rd & 32'h5, 32'h5);
		wr(IDX_FFLAG, 32'hFF);
		$display("test counted done");
		// repeating groups stopped gracefully through counted mode
		k = rnd(3) + 16'h1;
		wr(IDX_PNUM, 32'(k));
		wr(IDX_DIV, 32'h0);
		wr(IDX_MODE, 32'(MODE_IR));
		pulse_clr();
		wr(IDX_EN0, 32'h1);
		repeat (3 * k * (c + 2) + 10) @(posedge clk_sys);
		wr(IDX_MODE, 32'(MODE_COUNT));
		wait_off();
		chk(32'(rise0 >= 3 * k), 32'h1);
		chk(32'(rise0 % k), 32'h0);
		$display("test repeating done");
		// processor-fed queue: carrier, low and alternate elements
		wr(IDX_FLUSH, 32'h1);
		wr(IDX_MODE, 32'(MODE_QCPU));
		ac = rnd(3);
		n0 = rnd(7);
		n2 = rnd(7);
		wr(IDX_ALT_CMP, 32'(ac));
		wr(IDX_ALT_PER, 32'(ac + 16'h3));
		wr(IDX_WIN_FIRST, {16'h0003, 16'h8000 | n0});
		bus(1'b1, 11'h7C8, {24'h0, n2[7:0]}, 4'h1);
		bus(1'b1, 11'h7C9, 32'hC0, 4'h1);
		rdr(IDX_QSTAT);
		chk(rd, 32'h06);
		wr(IDX_THRESH, 32'h4);
		pulse_clr();
		wr(IDX_EN0, 32'h1);
		wait_off();
		chk(rd, 32'h0);
		chk(32'(rise0), 32'(n0 + n2));
		chk(32'(high0), 32'(n0 * c + n2 * ac));
		rdr(IDX_QFLAG);
		chk(32'(rd[0]), 32'h1);
		chk(32'(rd[1]), 32'h1);
		rdr(IDX_QSTAT);
		chk(rd, 32'h10);
		wr(IDX_QFLAG, 32'hFF);
		$display("test processor queue done");
		// full queue refuses, flush empties
		wr(IDX_WIN_FIRST, $random(seed));
		wr(IDX_WIN_FIRST, $random(seed));
		rdr(IDX_QSTAT);
		chk(rd, 32'h28);
		wr(IDX_WIN_FIRST, $random(seed));
		rdr(IDX_QSTAT);
		chk(rd, 32'h28);
		wr(IDX_FLUSH, 32'h1);
		rdr(IDX_QSTAT);
		chk(rd, 32'h10);
		$display("test full queue done");
		// dma-fed queue: start sets enable, word holds two elements
		wr(IDX_MODE, 32'(MODE_QDMA));
		pulse_clr();
		dma_start <= 1'b1;
		dma_word <= '{valid: 1'b1, data: {16'h8000 | n2, 16'hC000 | n0}};
		@(posedge clk_sys);
		dma_start <= 1'b0;
		for (i = 0; i < 100 && dma_ready !== 1'b1; i++)
			@(posedge clk_sys);
		dma_word.valid <= 1'b0;
		chk(32'(i < 100), 32'h1);
		wait_off();
		chk(32'(rise0), 32'(n0 + n2));
		chk(32'(high0), 32'(n0 * ac + n2 * c));
		rdr(IDX_QFLAG);
		chk(32'(rd[0]), 32'h1);
		$display("test dma queue done");
		summarize();
	end
endmodule : tb_pwm_modes_ir_fifo
`default_nettype wire
